// ---- hdl/bpl_pkg.sv ----
`default_nettype none
package bpl_pkg;
   // ------------------------------------------------------------
   // link timing
   // ------------------------------------------------------------
   localparam int          CLK_HZ      = 20_000_000;
   localparam int          BAUD        = 9600;
   localparam int          BIT_CYC     = CLK_HZ / BAUD;
   localparam int          HALF_CYC    = BIT_CYC / 2;
   localparam int          STATUS_MS   = 500;
   localparam int          STATUS_CYC  = (CLK_HZ / 1000) * STATUS_MS;
   localparam logic [11:0] BIT_LAST    = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_LAST   = 12'(HALF_CYC - 1);
   localparam logic [3:0]  STOP_BIT    = 4'h9;

   // ------------------------------------------------------------
   // frame layout
   // ------------------------------------------------------------
   localparam logic [7:0]  SYNC0       = 8'h73;
   localparam logic [7:0]  SYNC1       = 8'h6e;
   localparam logic [7:0]  SYNC2       = 8'h70;
   localparam int          KB_DATA     = 7;
   localparam int          KB_MULTI    = 6;
   localparam int          KB_LEN_HI   = 5;
   localparam int          KB_LEN_LO   = 2;
   localparam int          KB_FAIL     = 0;
   localparam logic [7:0]  KIND_DONE   = 8'h00;
   localparam logic [7:0]  KIND_FAIL   = 8'h01;
   localparam logic [7:0]  KIND_SINGLE = 8'h80;
   localparam logic [7:0]  KIND_STATUS = 8'hd0;
   localparam logic [7:0]  STATUS_ADDR = 8'h55;
   localparam logic [4:0]  STATUS_N    = 5'h04;
   localparam logic [7:0]  CMD_BASE    = 8'haa;
   localparam logic [6:0]  HDR_BYTES   = 7'h05;
   localparam logic [6:0]  FIXED_BYTES = 7'h07;
   localparam int          MAX_WORDS   = 16;

   typedef enum logic [2:0] {
      P_S0 = 3'b000, P_S1 = 3'b001, P_S2 = 3'b010, P_KIND = 3'b011,
      P_ADDR = 3'b100, P_DATA = 3'b101, P_CKHI = 3'b110, P_CKLO = 3'b111
   } bpl_parse_e;

   typedef enum logic [1:0] {
      E_IDLE = 2'b00, E_WRITE = 2'b01, E_CMD = 2'b10, E_SEND = 2'b11
   } bpl_eng_e;
endpackage
`default_nettype wire

// ---- hdl/bpl_link.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - every frame opens with bytes 73, 6e, 70 in that order
// - then kind byte, address byte, data section, two checksum bytes
// - kind bit 7 set when a data section is present
// - kind bit 6 set for a multi-register run
// - kind bits 5..2 give run length in registers
// - bit 1 reserved; failure bit 0 only sent, ignored on receive
// - address byte names read, write or first register of a run
// - no data flag: no data bytes, seven bytes in total
// - data without run flag: four data bytes, eleven in total
// - data with run flag: four bytes per register, seven plus that
// - read answer has data flag, copies run flag and length
// - after a write reply kind 00 with written or first address
// - kind 00 at command address invokes command, success echoes address
// - failed command replies like completion with failure bit set
// - commands with own reply send only that reply
// - in binary mode send status run d0 at 55 twice a second
// - first data word is addressed register, most significant byte first
// - link is asynchronous bytes at 9600 baud
// - run address steps by one per register
// - every register is 32 bits, four data bytes
module bpl_link
   import bpl_pkg::*;
#(
   parameter int STATUS_CYCLES = STATUS_CYC,
   parameter int BIT_CYCLES    = BIT_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        serial_rxd,
   output logic             serial_txd,
   input  wire logic        binary_mode,
   output logic [7:0]       reg_rd_addr,
   input  wire logic [31:0] reg_rd_data,
   output logic             reg_wr_en,
   output logic [7:0]       reg_wr_addr,
   output logic [31:0]      reg_wr_data,
   output logic             cmd_start,
   output logic [7:0]       cmd_addr,
   input  wire logic        cmd_done,
   input  wire logic        cmd_ok,
   input  wire logic        cmd_own_reply,
   output logic             frame_drop,
   output logic             busy
);
   // bit period is a parameter so that a bench can run the link fast
   localparam logic [11:0] BIT_END  = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALF_END = 12'(BIT_CYCLES / 2 - 1);

   // ------------------------------------------------------------
   // receive side
   // ------------------------------------------------------------
   logic        rxs1_ff, rxs2_ff;
   logic        rx_act_ff, nxt_rx_act;
   logic [11:0] rx_cnt_ff, nxt_rx_cnt;
   logic [3:0]  rx_bit_ff, nxt_rx_bit;
   logic [7:0]  rx_sh_ff, nxt_rx_sh;
   logic        rx_vld_ff, nxt_rx_vld;
   logic        rx_ferr_ff, nxt_rx_ferr;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxs1_ff <= 1'b1;
         rxs2_ff <= 1'b1;
      end else begin
         rxs1_ff <= serial_rxd;
         rxs2_ff <= rxs1_ff;
      end
   end

   // sample at mid-bit; a start bit that is gone at mid-bit is noise
   always_comb begin
      nxt_rx_act  = rx_act_ff;
      nxt_rx_cnt  = rx_cnt_ff;
      nxt_rx_bit  = rx_bit_ff;
      nxt_rx_sh   = rx_sh_ff;
      nxt_rx_vld  = 1'b0;
      nxt_rx_ferr = 1'b0;
      if (!rx_act_ff) begin
         if (!rxs2_ff) begin
            nxt_rx_act = 1'b1;
            nxt_rx_cnt = HALF_END;
            nxt_rx_bit = 4'h0;
         end
      end else if (rx_cnt_ff != 12'h000) begin
         nxt_rx_cnt = rx_cnt_ff - 12'h001;
      end else begin
         nxt_rx_cnt = BIT_END;
         nxt_rx_bit = rx_bit_ff + 4'h1;
         if (rx_bit_ff == 4'h0) begin
            nxt_rx_act = ~rxs2_ff;
         end else if (rx_bit_ff == STOP_BIT) begin
            nxt_rx_act  = 1'b0;
            nxt_rx_vld  = rxs2_ff;
            nxt_rx_ferr = ~rxs2_ff;
         end else begin
            nxt_rx_sh = {rxs2_ff, rx_sh_ff[7:1]};
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_act_ff  <= 1'b0;
         rx_cnt_ff  <= 12'h000;
         rx_bit_ff  <= 4'h0;
         rx_sh_ff   <= 8'h00;
         rx_vld_ff  <= 1'b0;
         rx_ferr_ff <= 1'b0;
      end else begin
         rx_act_ff  <= nxt_rx_act;
         rx_cnt_ff  <= nxt_rx_cnt;
         rx_bit_ff  <= nxt_rx_bit;
         rx_sh_ff   <= nxt_rx_sh;
         rx_vld_ff  <= nxt_rx_vld;
         rx_ferr_ff <= nxt_rx_ferr;
      end
   end

   // ------------------------------------------------------------
   // frame parser
   // ------------------------------------------------------------
   bpl_parse_e  p_st_ff, nxt_p_st;
   bpl_eng_e    e_st_ff;
   logic [15:0] p_sum_ff, nxt_p_sum;
   logic [7:0]  p_kind_ff, nxt_p_kind;
   logic [7:0]  p_addr_ff, nxt_p_addr;
   logic [5:0]  p_cnt_ff, nxt_p_cnt;
   logic [31:0] p_word_ff, nxt_p_word;
   logic [3:0]  p_wi_ff, nxt_p_wi;
   logic [7:0]  p_ckhi_ff, nxt_p_ckhi;
   logic        p_req_ff, nxt_p_req;
   logic        p_drop_ff, nxt_p_drop;
   logic        mem_we;
   logic [31:0] mem [0:MAX_WORDS-1];
   logic [5:0]  kind_bytes;
   logic [7:0]  rb;

   assign rb = rx_sh_ff;

   always_comb begin
      nxt_p_st   = p_st_ff;
      nxt_p_sum  = p_sum_ff + {8'h00, rb};
      nxt_p_kind = p_kind_ff;
      nxt_p_addr = p_addr_ff;
      nxt_p_cnt  = p_cnt_ff;
      nxt_p_word = p_word_ff;
      nxt_p_wi   = p_wi_ff;
      nxt_p_ckhi = p_ckhi_ff;
      nxt_p_req  = 1'b0;
      nxt_p_drop = 1'b0;
      mem_we     = 1'b0;
      kind_bytes = 6'h00;
      if (rb[KB_DATA]) begin
         kind_bytes = rb[KB_MULTI] ? {rb[KB_LEN_HI:KB_LEN_LO], 2'b00} : 6'h04;
      end
      if (rx_ferr_ff) begin
         nxt_p_st   = P_S0;
         nxt_p_drop = (p_st_ff != P_S0);
      end else if (rx_vld_ff) begin
         unique case (p_st_ff)
            P_S0: begin
               nxt_p_sum = {8'h00, rb};
               if (rb == SYNC0) nxt_p_st = P_S1;
            end
            P_S1: begin
               nxt_p_st = (rb == SYNC1) ? P_S2 : (rb == SYNC0) ? P_S1 : P_S0;
               // a repeated first start byte opens a fresh sum
               if (rb != SYNC1) nxt_p_sum = {8'h00, rb};
            end
            P_S2: begin
               nxt_p_st = (rb == SYNC2) ? P_KIND : (rb == SYNC0) ? P_S1 : P_S0;
               if (rb != SYNC2) nxt_p_sum = {8'h00, rb};
            end
            P_KIND: begin
               nxt_p_kind = rb;
               nxt_p_cnt  = kind_bytes;
               nxt_p_wi   = 4'h0;
               nxt_p_st   = P_ADDR;
               // a zero-length run is refused for reads as well as writes
               if (rb[KB_MULTI] && rb[KB_LEN_HI:KB_LEN_LO] == 4'h0) begin
                  nxt_p_st   = P_S0;
                  nxt_p_drop = 1'b1;
               end
            end
            P_ADDR: begin
               nxt_p_addr = rb;
               nxt_p_st   = (p_cnt_ff == 6'h00) ? P_CKHI : P_DATA;
            end
            P_DATA: begin
               nxt_p_word = {p_word_ff[23:0], rb};
               nxt_p_cnt  = p_cnt_ff - 6'h01;
               if (p_cnt_ff[1:0] == 2'b01) begin
                  mem_we   = 1'b1;
                  nxt_p_wi = p_wi_ff + 4'h1;
               end
               if (p_cnt_ff == 6'h01) nxt_p_st = P_CKHI;
            end
            P_CKHI: begin
               nxt_p_sum  = p_sum_ff;
               nxt_p_ckhi = rb;
               nxt_p_st   = P_CKLO;
            end
            P_CKLO: begin
               nxt_p_sum = p_sum_ff;
               nxt_p_st  = P_S0;
               // frames arriving while a reply is still running are dropped
               if ({p_ckhi_ff, rb} == p_sum_ff && e_st_ff == E_IDLE) begin
                  nxt_p_req = 1'b1;
               end else begin
                  nxt_p_drop = 1'b1;
               end
            end
         endcase
      end else begin
         nxt_p_sum = p_sum_ff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mem_we) mem[p_wi_ff] <= {p_word_ff[23:0], rb};
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         p_st_ff   <= P_S0;
         p_sum_ff  <= 16'h0000;
         p_kind_ff <= 8'h00;
         p_addr_ff <= 8'h00;
         p_cnt_ff  <= 6'h00;
         p_word_ff <= 32'h0000_0000;
         p_wi_ff   <= 4'h0;
         p_ckhi_ff <= 8'h00;
         p_req_ff  <= 1'b0;
         p_drop_ff <= 1'b0;
      end else begin
         p_st_ff   <= nxt_p_st;
         p_sum_ff  <= nxt_p_sum;
         p_kind_ff <= nxt_p_kind;
         p_addr_ff <= nxt_p_addr;
         p_cnt_ff  <= nxt_p_cnt;
         p_word_ff <= nxt_p_word;
         p_wi_ff   <= nxt_p_wi;
         p_ckhi_ff <= nxt_p_ckhi;
         p_req_ff  <= nxt_p_req;
         p_drop_ff <= nxt_p_drop;
      end
   end

   // ------------------------------------------------------------
   // execute and reply
   // ------------------------------------------------------------
   bpl_eng_e    nxt_e_st;
   logic [7:0]  e_kind_ff, nxt_e_kind, e_addr_ff, nxt_e_addr;
   logic [4:0]  e_n_ff, nxt_e_n;
   logic [3:0]  e_wi_ff, nxt_e_wi;
   logic [6:0]  e_bi_ff, nxt_e_bi, e_tot_ff, nxt_e_tot, e_doff;
   logic [15:0] e_sum_ff, nxt_e_sum;
   logic [31:0] e_word_ff, nxt_e_word, wr_data_ff, nxt_wr_data;
   logic [7:0]  rd_addr_ff, nxt_rd_addr, wr_addr_ff, nxt_wr_addr;
   logic        wr_en_ff, nxt_wr_en, cmd_ff, nxt_cmd;
   logic        pend_ff, nxt_pend;
   logic [23:0] st_cnt_ff, nxt_st_cnt;
   logic        tx_busy_ff, tx_load;
   logic [7:0]  tx_byte;

   assign e_doff = e_bi_ff - HDR_BYTES;

   always_comb begin
      nxt_e_st    = e_st_ff;
      nxt_e_kind  = e_kind_ff;
      nxt_e_addr  = e_addr_ff;
      nxt_e_n     = e_n_ff;
      nxt_e_wi    = e_wi_ff;
      nxt_e_bi    = e_bi_ff;
      nxt_e_tot   = FIXED_BYTES + {e_n_ff, 2'b00};
      nxt_e_sum   = e_sum_ff;
      nxt_e_word  = e_word_ff;
      nxt_rd_addr = rd_addr_ff;
      nxt_wr_en   = 1'b0;
      nxt_wr_addr = wr_addr_ff;
      nxt_wr_data = wr_data_ff;
      nxt_cmd     = 1'b0;
      nxt_pend    = pend_ff;
      nxt_st_cnt  = st_cnt_ff + 24'h000001;
      tx_load     = 1'b0;
      tx_byte     = 8'h00;
      unique case (e_st_ff)
         E_IDLE: begin
            nxt_e_addr  = p_addr_ff;
            nxt_rd_addr = p_addr_ff;
            nxt_e_wi    = 4'h0;
            nxt_e_bi    = 7'h00;
            nxt_e_sum   = 16'h0000;
            nxt_e_n     = p_kind_ff[KB_MULTI] ? {1'b0, p_kind_ff[KB_LEN_HI:KB_LEN_LO]} : 5'h01;
            if (p_req_ff) begin
               if (p_kind_ff[KB_DATA]) begin
                  nxt_e_st = E_WRITE;
               end else if (p_addr_ff >= CMD_BASE) begin
                  nxt_cmd  = 1'b1;
                  nxt_e_st = E_CMD;
               end else begin
                  // bit 0 of the request is not copied back
                  nxt_e_kind = {1'b1, p_kind_ff[KB_MULTI:KB_LEN_LO], 2'b00};
                  nxt_e_st   = E_SEND;
               end
            end else if (pend_ff && binary_mode) begin
               nxt_pend    = 1'b0;
               nxt_e_kind  = KIND_STATUS;
               nxt_e_addr  = STATUS_ADDR;
               nxt_rd_addr = STATUS_ADDR;
               nxt_e_n     = STATUS_N;
               nxt_e_st    = E_SEND;
            end
         end
         E_WRITE: begin
            nxt_wr_en   = 1'b1;
            nxt_wr_addr = e_addr_ff + {4'h0, e_wi_ff};
            nxt_wr_data = mem[e_wi_ff];
            nxt_e_wi    = e_wi_ff + 4'h1;
            if ({1'b0, e_wi_ff} == e_n_ff - 5'h01) begin
               nxt_e_kind = KIND_DONE;
               nxt_e_n    = 5'h00;
               nxt_e_st   = E_SEND;
            end
         end
         E_CMD: begin
            if (cmd_done) begin
               nxt_e_st = E_SEND;
               nxt_e_n  = 5'h00;
               if (!cmd_ok) begin
                  nxt_e_kind = KIND_FAIL;
               end else if (cmd_own_reply) begin
                  nxt_e_kind = KIND_SINGLE;
                  nxt_e_n    = 5'h01;
               end else begin
                  nxt_e_kind = KIND_DONE;
               end
            end
         end
         E_SEND: begin
            if (!tx_busy_ff) begin
               tx_load  = 1'b1;
               nxt_e_bi = e_bi_ff + 7'h01;
               if (e_bi_ff == 7'h00) tx_byte = SYNC0;
               else if (e_bi_ff == 7'h01) tx_byte = SYNC1;
               else if (e_bi_ff == 7'h02) tx_byte = SYNC2;
               else if (e_bi_ff == 7'h03) tx_byte = e_kind_ff;
               else if (e_bi_ff == 7'h04) tx_byte = e_addr_ff;
               else if (e_bi_ff == e_tot_ff - 7'h02) tx_byte = e_sum_ff[15:8];
               else if (e_bi_ff == e_tot_ff - 7'h01) tx_byte = e_sum_ff[7:0];
               else if (e_doff[1:0] == 2'b00) begin
                  // latch the whole word so the four bytes stay coherent
                  tx_byte     = reg_rd_data[31:24];
                  nxt_e_word  = {reg_rd_data[23:0], 8'h00};
                  nxt_rd_addr = rd_addr_ff + 8'h01;
               end else begin
                  tx_byte    = e_word_ff[31:24];
                  nxt_e_word = {e_word_ff[23:0], 8'h00};
               end
               if (e_bi_ff < e_tot_ff - 7'h02) nxt_e_sum = e_sum_ff + {8'h00, tx_byte};
               if (e_bi_ff == e_tot_ff - 7'h01) nxt_e_st = E_IDLE;
            end
         end
      endcase
      // after the case so a new tick wins over clearing the one being served
      if (!binary_mode) begin
         nxt_st_cnt = 24'h000000;
         nxt_pend   = 1'b0;
      end else if (st_cnt_ff == 24'(STATUS_CYCLES - 1)) begin
         nxt_st_cnt = 24'h000000;
         nxt_pend   = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         e_st_ff    <= E_IDLE;
         e_kind_ff  <= 8'h00;
         e_addr_ff  <= 8'h00;
         e_n_ff     <= 5'h00;
         e_wi_ff    <= 4'h0;
         e_bi_ff    <= 7'h00;
         e_tot_ff   <= 7'h07;
         e_sum_ff   <= 16'h0000;
         e_word_ff  <= 32'h0000_0000;
         rd_addr_ff <= 8'h00;
         wr_en_ff   <= 1'b0;
         wr_addr_ff <= 8'h00;
         wr_data_ff <= 32'h0000_0000;
         cmd_ff     <= 1'b0;
         pend_ff    <= 1'b0;
         st_cnt_ff  <= 24'h000000;
      end else begin
         e_st_ff    <= nxt_e_st;
         e_kind_ff  <= nxt_e_kind;
         e_addr_ff  <= nxt_e_addr;
         e_n_ff     <= nxt_e_n;
         e_wi_ff    <= nxt_e_wi;
         e_bi_ff    <= nxt_e_bi;
         e_tot_ff   <= nxt_e_tot;
         e_sum_ff   <= nxt_e_sum;
         e_word_ff  <= nxt_e_word;
         rd_addr_ff <= nxt_rd_addr;
         wr_en_ff   <= nxt_wr_en;
         wr_addr_ff <= nxt_wr_addr;
         wr_data_ff <= nxt_wr_data;
         cmd_ff     <= nxt_cmd;
         pend_ff    <= nxt_pend;
         st_cnt_ff  <= nxt_st_cnt;
      end
   end

   // ------------------------------------------------------------
   // transmit side
   // ------------------------------------------------------------
   logic [11:0] tx_cnt_ff, nxt_tx_cnt;
   logic [3:0]  tx_bit_ff, nxt_tx_bit;
   logic [9:0]  tx_sh_ff, nxt_tx_sh;
   logic        nxt_tx_busy;

   always_comb begin
      nxt_tx_busy = tx_busy_ff;
      nxt_tx_cnt  = tx_cnt_ff;
      nxt_tx_bit  = tx_bit_ff;
      nxt_tx_sh   = tx_sh_ff;
      if (tx_load) begin
         nxt_tx_busy = 1'b1;
         nxt_tx_cnt  = BIT_END;
         nxt_tx_bit  = 4'h0;
         nxt_tx_sh   = {1'b1, tx_byte, 1'b0};
      end else if (tx_busy_ff) begin
         if (tx_cnt_ff != 12'h000) begin
            nxt_tx_cnt = tx_cnt_ff - 12'h001;
         end else begin
            nxt_tx_cnt  = BIT_END;
            nxt_tx_bit  = tx_bit_ff + 4'h1;
            nxt_tx_sh   = {1'b1, tx_sh_ff[9:1]};
            nxt_tx_busy = (tx_bit_ff != STOP_BIT);
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_busy_ff <= 1'b0;
         tx_cnt_ff  <= 12'h000;
         tx_bit_ff  <= 4'h0;
         tx_sh_ff   <= 10'h3ff;
      end else begin
         tx_busy_ff <= nxt_tx_busy;
         tx_cnt_ff  <= nxt_tx_cnt;
         tx_bit_ff  <= nxt_tx_bit;
         tx_sh_ff   <= nxt_tx_sh;
      end
   end

   assign serial_txd  = tx_sh_ff[0];
   assign reg_rd_addr = rd_addr_ff;
   assign reg_wr_en   = wr_en_ff;
   assign reg_wr_addr = wr_addr_ff;
   assign reg_wr_data = wr_data_ff;
   assign cmd_start   = cmd_ff;
   assign cmd_addr    = e_addr_ff;
   assign frame_drop  = p_drop_ff;
   assign busy        = (e_st_ff != E_IDLE) | tx_busy_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_SYNC_FIRST: assert property (@(posedge core_clk) disable iff (sys_rst)
      tx_load && e_bi_ff == 7'h00 |-> tx_byte == 8'h73)
      else $error("frame does not open with first start byte");
   AST_LEN_TOTAL: assert property (@(posedge core_clk) disable iff (sys_rst)
      tx_load && e_bi_ff == 7'h04 |-> e_tot_ff == 7'd7 + {e_n_ff, 2'b00})
      else $error("reply length differs from seven plus four per word");
   AST_HUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
      rx_ferr_ff |=> p_st_ff == P_S0)
      else $error("broken byte did not restart the hunt");
   AST_RUN_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
      reg_wr_en && $past(reg_wr_en) |-> reg_wr_addr == $past(reg_wr_addr) + 8'h01)
      else $error("run write address did not step by one");
   AST_WRITE_DONE: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(reg_wr_en) |-> e_kind_ff == 8'h00 && e_st_ff == E_SEND)
      else $error("write not followed by completion");
   AST_CMD_FAIL: assert property (@(posedge core_clk) disable iff (sys_rst)
      e_st_ff == E_CMD && cmd_done && !cmd_ok |=> e_kind_ff == 8'h01)
      else $error("failed command not flagged");
   AST_READ_REPLY: assert property (@(posedge core_clk) disable iff (sys_rst)
      e_st_ff == E_IDLE && p_req_ff && !p_kind_ff[7] && p_addr_ff < 8'haa
      |=> e_kind_ff[7] && e_kind_ff[6:2] == $past(p_kind_ff[6:2]))
      else $error("read answer kind does not mirror request");
   AST_STATUS: assert property (@(posedge core_clk) disable iff (sys_rst)
      e_st_ff == E_IDLE && !p_req_ff && pend_ff && binary_mode
      |=> e_kind_ff == 8'hd0 && e_addr_ff == 8'h55 && e_n_ff == 5'h04)
      else $error("status frame header wrong");
endmodule
`default_nettype wire

// ---- test/bpl_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module bpl_host
   import bpl_pkg::*;
#(
   parameter int BIT_CYCLES = BIT_CYC
) (
   input  wire logic core_clk,
   input  wire logic serial_txd,
   output var logic  serial_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] rb;
   initial serial_rxd = 1'b1;
   // ----------------
   // host to device
   // ----------------
   // caller sends one request and waits for its reply before the next
   task automatic put_bytes(input logic [7:0] f[$]);
      logic [9:0] sh;
      foreach (f[k]) begin
         sh = {1'b1, f[k], 1'b0};
         for (int i = 0; i < 10; i++) begin
            serial_rxd = sh[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
            #1;
         end
      end
   endtask
   // sample mid-bit, lsb first; clear of the launching edge
   always begin
      @(negedge serial_txd);
      repeat (BIT_CYCLES / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge core_clk);
         #1;
         rb[i] = serial_txd;
      end
      rx_q.push_back(rb);
      repeat (BIT_CYCLES) @(posedge core_clk);
   end
endmodule
`default_nettype wire

// ---- test/bpl_link_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bpl_link_tb;
   import bpl_pkg::*;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cmd_done = 1'b0;
   logic        binary_mode = 1'b0, cmd_ok = 1'b0, cmd_own_reply = 1'b0;
   // fast link and short status period keep the run short
   localparam int SIM_BIT = 16, SIM_STAT = 5000;
   logic        serial_rxd, serial_txd, reg_wr_en, cmd_start, frame_drop, busy;
   logic [7:0]  reg_rd_addr, reg_wr_addr, cmd_addr, last_a, last_c;
   logic [31:0] reg_rd_data, reg_wr_data, last_d;
   int          err_total = 0, tests_run = 0, wr_cnt = 0, drop_cnt = 0;
   always #25 core_clk = ~core_clk;
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      return {a, ~a, a ^ 8'h5a, 8'hc3};
   endfunction
   assign reg_rd_data = rd_word(reg_rd_addr);
   // every command ends one cycle after it starts
   always @(posedge core_clk) cmd_done <= cmd_start;
   bpl_link #(.STATUS_CYCLES(SIM_STAT), .BIT_CYCLES(SIM_BIT)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .serial_rxd(serial_rxd),
      .serial_txd(serial_txd), .binary_mode(binary_mode), .reg_rd_addr(reg_rd_addr),
      .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .cmd_start(cmd_start), .cmd_addr(cmd_addr),
      .cmd_done(cmd_done), .cmd_ok(cmd_ok), .cmd_own_reply(cmd_own_reply),
      .frame_drop(frame_drop), .busy(busy));
   bpl_host #(.BIT_CYCLES(SIM_BIT)) host (.core_clk(core_clk), .serial_txd(serial_txd),
      .serial_rxd(serial_rxd));
   always @(posedge core_clk) begin
      #1;
      if (reg_wr_en === 1'b1) begin
         wr_cnt++;
         last_a = reg_wr_addr;
         last_d = reg_wr_data;
      end
      if (frame_drop === 1'b1) drop_cnt++;
      if (cmd_start === 1'b1) last_c = cmd_addr;
   end
   task automatic end_sim();
      $display("tests %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic void mk(input logic [7:0] kind, input logic [7:0] addr,
                              input logic [31:0] w[$], output logic [7:0] f[$]);
      logic [15:0] s;
      f = {SYNC0, SYNC1, SYNC2, kind, addr};
      foreach (w[i]) for (int j = 3; j >= 0; j--) f.push_back(w[i][8*j +: 8]);
      s = 16'h0000;
      foreach (f[i]) s = s + 16'(f[i]);
      f.push_back(s[15:8]);
      f.push_back(s[7:0]);
   endfunction
   // send a request, then demand exactly the expected reply bytes
   task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$]);
      int n;
      host.rx_q.delete();
      host.put_bytes(q);
      n = 0;
      while (host.rx_q.size() < e.size()
             && n < 12 * SIM_BIT * (e.size() + 2) + SIM_STAT) begin
         @(posedge core_clk);
         n++;
      end
      if (host.rx_q.size() < e.size()) begin
         chk(32'(host.rx_q.size()), 32'(e.size()));
         end_sim();
      end else begin
         foreach (e[i]) chk(32'(host.rx_q[i]), 32'(e[i]));
         repeat (3 * SIM_BIT) @(posedge core_clk);
         #1;
         chk(32'(host.rx_q.size()), 32'(e.size()));
         chk({31'h0, busy}, 32'h0);
      end
   endtask
   initial begin
      logic [7:0]  q[$], e[$], a;
      logic [31:0] w[$], d;
      a = 8'($urandom(41164));
      repeat (4) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      w = {};
      e = {};
      mk(8'h40, 8'h20, w, q);
      xfer(q, e);
      mk(8'h00, 8'h20, w, q);
      q[6] = q[6] ^ 8'h01;
      xfer(q, e);
      chk(32'(drop_cnt), 32'h2);
      a = 8'($urandom_range(168));
      mk(8'h48, a, w, q);
      w = {rd_word(a), rd_word(a + 8'h01)};
      mk(8'hc8, a, w, e);
      xfer(q, e);
      d = $urandom();
      w = {d};
      mk(8'h80, a, w, q);
      w = {};
      mk(8'h00, a, w, e);
      xfer(q, e);
      chk(32'(wr_cnt), 32'h1);
      chk({24'h0, last_a}, {24'h0, a});
      chk(last_d, d);
      w = {d, ~d};
      mk(8'hc8, a, w, q);
      w = {};
      mk(8'h00, a, w, e);
      xfer(q, e);
      chk(32'(wr_cnt), 32'h3);
      chk({24'h0, last_a}, {24'h0, a + 8'h01});
      chk(last_d, ~d);
      mk(8'h00, CMD_BASE, w, q);
      mk(8'h01, CMD_BASE, w, e);
      xfer(q, e);
      chk({24'h0, last_c}, {24'h0, CMD_BASE});
      cmd_ok = 1'b1;
      mk(8'h00, CMD_BASE + 8'h01, w, q);
      mk(8'h00, CMD_BASE + 8'h01, w, e);
      xfer(q, e);
      cmd_own_reply = 1'b1;
      mk(8'h00, CMD_BASE + 8'h02, w, q);
      w = {rd_word(CMD_BASE + 8'h02)};
      mk(8'h80, CMD_BASE + 8'h02, w, e);
      xfer(q, e);
      w = {rd_word(8'h55), rd_word(8'h56), rd_word(8'h57), rd_word(8'h58)};
      mk(KIND_STATUS, STATUS_ADDR, w, e);
      q = {};
      binary_mode = 1'b1;
      xfer(q, e);
      binary_mode = 1'b0;
      end_sim();
   end
endmodule
`default_nettype wire
